// *** rtl/sar_adc_dac_control.v ***
// register file and sequencer of the shared 12-bit converter behind an AXI4-Lite slave
`timescale 1ns/1ps
module sar_adc_dac_control (
    // clock and reset
    input  wire        core_clk_in,
    input  wire        rst_in,
    // axi4-lite write address
    input  wire [7:0]  s_axi_awaddr_in,
    input  wire        s_axi_awvalid_in,
    output reg         s_axi_awready_out,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata_in,
    input  wire [3:0]  s_axi_wstrb_in,
    input  wire        s_axi_wvalid_in,
    output reg         s_axi_wready_out,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp_out,
    output reg         s_axi_bvalid_out,
    input  wire        s_axi_bready_in,
    // axi4-lite read address
    input  wire [7:0]  s_axi_araddr_in,
    input  wire        s_axi_arvalid_in,
    output reg         s_axi_arready_out,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata_out,
    output reg  [1:0]  s_axi_rresp_out,
    output reg         s_axi_rvalid_out,
    input  wire        s_axi_rready_in,
    // analog core
    output reg         core_sample_go_out,
    output reg         core_output_go_out,
    output reg  [11:0] core_output_code_out,
    input  wire        core_done_in,
    input  wire [11:0] core_sample_in,
    // analog core setup and switch matrix
    output reg  [9:0]  core_setup_out,
    output reg  [19:0] input_switch_out,
    output reg  [19:0] output_switch_out,
    // interrupt
    output reg         irq_out
);
`include "sar_converter_map.vh"

    localparam [2:0] ST_IDLE   = 3'b001;
    localparam [2:0] ST_SAMPLE = 3'b010;
    localparam [2:0] ST_OUTPUT = 3'b100;

    localparam [1:0] RESP_OKAY   = 2'b00;
    localparam [1:0] RESP_SLVERR = 2'b10;

    // only the external lines are wired; reserved inputs never close
    localparam [19:0] SWITCH_USED = 20'h0_003F;

    // ==========================================================
    // registers
    reg [5:0]  converter_control;
    reg [11:0] conversion_result;
    reg [11:0] output_level_value;
    reg [9:0]  converter_setup;
    reg [19:0] input_switch_select;
    reg [19:0] output_switch_select;
    reg [15:0] low_threshold;
    reg [15:0] high_threshold;
    reg [3:0]  interrupt_enable;
    reg [3:0]  raw_interrupt_status;
    reg [2:0]  state;
    reg        last_was_sample;
    reg [7:0]  wr_addr;
    reg [31:0] wr_data;
    reg [3:0]  wr_strb;
    reg        have_addr;
    reg        have_data;

    wire [3:0] enabled_interrupt_status = raw_interrupt_status & interrupt_enable;
    wire       pace_ready;
    wire       sample_req = converter_control[`BIT_SAMPLE_START] & pace_ready;
    wire       output_req = converter_control[`BIT_OUTPUT_START];
    wire       write_fire = have_addr & have_data & ~s_axi_bvalid_out;
    wire       start_sample;
    wire       start_output;
    wire       finish_sample = (state == ST_SAMPLE) & core_done_in;
    wire       finish_output = (state == ST_OUTPUT) & core_done_in;

    // byte-lane merge of a write into an existing word
    function [31:0] merge_lanes;
        input [31:0] old_word;
        input [31:0] new_word;
        input [3:0]  strb;
        integer k;
        begin
            merge_lanes = old_word;
            for (k = 0; k < 4; k = k + 1) begin
                if (strb[k])
                    merge_lanes[8*k +: 8] = new_word[8*k +: 8];
            end
        end
    endfunction

    function is_mapped;
        input [7:0] addr;
        begin
            case (addr)
                `OFS_CONVERTER_CONTROL, `OFS_CONVERSION_RESULT, `OFS_OUTPUT_LEVEL_VALUE,
                `OFS_CONVERTER_SETUP, `OFS_INPUT_SWITCH_SELECT, `OFS_OUTPUT_SWITCH_SELECT,
                `OFS_LOW_THRESHOLD, `OFS_HIGH_THRESHOLD, `OFS_INTERRUPT_ENABLE,
                `OFS_RAW_INTERRUPT_STATUS, `OFS_ENABLED_INTERRUPT_STATUS,
                `OFS_INTERRUPT_CLEAR: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    wire [31:0] wr_word = merge_lanes(32'h0000_0000, wr_data, wr_strb);
    wire        wr_ctl  = write_fire & (wr_addr == `OFS_CONVERTER_CONTROL);

    // strobed merges of a write into the current content of each register except control and interrupt enable
    wire [31:0] level_merged  = merge_lanes({20'h0_0000, output_level_value}, wr_data, wr_strb);
    wire [31:0] setup_merged  = merge_lanes({22'h00_0000, converter_setup}, wr_data, wr_strb);
    wire [31:0] in_sw_merged  = merge_lanes({12'h000, input_switch_select}, wr_data, wr_strb);
    wire [31:0] out_sw_merged = merge_lanes({12'h000, output_switch_select}, wr_data, wr_strb);
    wire [31:0] low_merged    = merge_lanes({16'h0000, low_threshold}, wr_data, wr_strb);
    wire [31:0] high_merged   = merge_lanes({16'h0000, high_threshold}, wr_data, wr_strb);

    // ==========================================================
    // arbitration: alternate when both directions wait
    assign start_sample = (state == ST_IDLE) & sample_req &
                          (~output_req | ~last_was_sample);
    assign start_output = (state == ST_IDLE) & output_req & ~start_sample;

    conversion_pacer u_pacer (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .restart_in  (start_sample),
        .ready_out   (pace_ready)
    );

    // ==========================================================
    // sequencer
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state                <= ST_IDLE;
            last_was_sample      <= 1'b0;
            core_sample_go_out   <= 1'b0;
            core_output_go_out   <= 1'b0;
            core_output_code_out <= `RST_DATA;
        end else begin
            core_sample_go_out <= 1'b0;
            core_output_go_out <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start_sample) begin
                        state              <= ST_SAMPLE;
                        last_was_sample    <= 1'b1;
                        core_sample_go_out <= 1'b1;
                    end else if (start_output) begin
                        state                <= ST_OUTPUT;
                        last_was_sample      <= 1'b0;
                        core_output_go_out   <= 1'b1;
                        // code latched at start only, so later writes wait for a start
                        core_output_code_out <= output_level_value;
                    end
                end
                // output code is untouched here, the hold amplifier keeps the level
                ST_SAMPLE: if (core_done_in) state <= ST_IDLE;
                ST_OUTPUT: if (core_done_in) state <= ST_IDLE;
                default:   state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // control register: software sets, sequencer clears start and stop at completion of a single or stopped run
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            converter_control <= `RST_CONTROL;
        end else begin
            if (finish_sample &&
                (!converter_control[`BIT_SAMPLE_CONTINUOUS] ||
                 converter_control[`BIT_SAMPLE_STOP])) begin
                converter_control[`BIT_SAMPLE_START] <= 1'b0;
                converter_control[`BIT_SAMPLE_STOP]  <= 1'b0;
            end
            if (finish_output &&
                (!converter_control[`BIT_OUTPUT_CONTINUOUS] ||
                 converter_control[`BIT_OUTPUT_STOP])) begin
                converter_control[`BIT_OUTPUT_START] <= 1'b0;
                converter_control[`BIT_OUTPUT_STOP]  <= 1'b0;
            end
            // a write in the completion cycle wins, so a fresh start is never lost
            if (wr_ctl)
                converter_control <= wr_word[5:0];
        end
    end

    // ==========================================================
    // result, thresholds and interrupt status
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            conversion_result    <= `RST_DATA;
            raw_interrupt_status <= `RST_RAW_STATUS;
        end else begin
            // clear first so that a same-cycle event wins
            if (write_fire && wr_addr == `OFS_INTERRUPT_CLEAR)
                raw_interrupt_status <= raw_interrupt_status & ~wr_word[3:0];
            if (finish_sample) begin
                conversion_result <= core_sample_in;
                raw_interrupt_status[`IRQ_SAMPLE_READY] <= 1'b1;
                if ({4'h0, core_sample_in} < low_threshold)
                    raw_interrupt_status[`IRQ_BELOW_LOW] <= 1'b1;
                if ({4'h0, core_sample_in} > high_threshold)
                    raw_interrupt_status[`IRQ_ABOVE_HIGH] <= 1'b1;
            end
            if (finish_output)
                raw_interrupt_status[`IRQ_OUTPUT_DONE] <= 1'b1;
        end
    end

    // ==========================================================
    // software-written registers
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            output_level_value   <= `RST_DATA;
            converter_setup      <= `RST_SETUP;
            input_switch_select  <= `RST_SWITCH;
            output_switch_select <= `RST_SWITCH;
            low_threshold        <= `RST_THRESHOLD;
            high_threshold       <= `RST_THRESHOLD;
            interrupt_enable     <= `RST_ENABLE;
        end else if (write_fire) begin
            case (wr_addr)
                `OFS_OUTPUT_LEVEL_VALUE:   output_level_value   <= level_merged[11:0];
                `OFS_CONVERTER_SETUP:      converter_setup      <= setup_merged[9:0];
                `OFS_INPUT_SWITCH_SELECT:  input_switch_select  <= in_sw_merged[19:0];
                `OFS_OUTPUT_SWITCH_SELECT: output_switch_select <= out_sw_merged[19:0];
                `OFS_LOW_THRESHOLD:        low_threshold        <= low_merged[15:0];
                `OFS_HIGH_THRESHOLD:       high_threshold       <= high_merged[15:0];
                `OFS_INTERRUPT_ENABLE: interrupt_enable <= wr_word[3:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // outputs toward the analog side and the interrupt line
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            core_setup_out    <= `RST_SETUP;
            input_switch_out  <= `RST_SWITCH;
            output_switch_out <= `RST_SWITCH;
            irq_out           <= 1'b0;
        end else begin
            core_setup_out    <= converter_setup;
            input_switch_out  <= input_switch_select & SWITCH_USED;
            output_switch_out <= output_switch_select & SWITCH_USED;
            irq_out           <= |enabled_interrupt_status;
        end
    end

    // ==========================================================
    // axi4-lite write channel
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= RESP_OKAY;
            have_addr         <= 1'b0;
            have_data         <= 1'b0;
            wr_addr           <= 8'h00;
            wr_data           <= 32'h0000_0000;
            wr_strb           <= 4'h0;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                wr_addr           <= {s_axi_awaddr_in[7:2], 2'b00};
                have_addr         <= 1'b1;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                wr_data          <= s_axi_wdata_in;
                wr_strb          <= s_axi_wstrb_in;
                have_data        <= 1'b1;
                s_axi_wready_out <= 1'b0;
            end
            if (write_fire) begin
                have_addr        <= 1'b0;
                have_data        <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out  <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out  <= 1'b1;
            end
        end
    end

    // ==========================================================
    // axi4-lite read channel; write-only registers read as zero
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rresp_out   <= is_mapped({s_axi_araddr_in[7:2], 2'b00}) ?
                                 RESP_OKAY : RESP_SLVERR;
            case ({s_axi_araddr_in[7:2], 2'b00})
                `OFS_CONVERTER_CONTROL:    s_axi_rdata_out <= {26'h000_0000, converter_control};
                `OFS_CONVERSION_RESULT:    s_axi_rdata_out <= {20'h0_0000, conversion_result};
                `OFS_CONVERTER_SETUP:      s_axi_rdata_out <= {22'h00_0000, converter_setup};
                `OFS_INPUT_SWITCH_SELECT:  s_axi_rdata_out <= {12'h000, input_switch_select};
                `OFS_OUTPUT_SWITCH_SELECT: s_axi_rdata_out <= {12'h000, output_switch_select};
                `OFS_LOW_THRESHOLD:        s_axi_rdata_out <= {16'h0000, low_threshold};
                `OFS_HIGH_THRESHOLD:       s_axi_rdata_out <= {16'h0000, high_threshold};
                `OFS_INTERRUPT_ENABLE:     s_axi_rdata_out <= {28'h000_0000, interrupt_enable};
                `OFS_RAW_INTERRUPT_STATUS: s_axi_rdata_out <=
                    {28'h000_0000, raw_interrupt_status};
                `OFS_ENABLED_INTERRUPT_STATUS: s_axi_rdata_out <=
                    {28'h000_0000, enabled_interrupt_status};
                default:                   s_axi_rdata_out <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out  <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end

endmodule // sar_adc_dac_control

// *** rtl/sar_converter_map.vh ***
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef SAR_CONVERTER_MAP_VH
`define SAR_CONVERTER_MAP_VH

// ==========================================================
// register byte offsets
`define OFS_CONVERTER_CONTROL       8'h00
`define OFS_CONVERSION_RESULT       8'h04
`define OFS_OUTPUT_LEVEL_VALUE      8'h08
`define OFS_CONVERTER_SETUP         8'h10
`define OFS_INPUT_SWITCH_SELECT     8'h18
`define OFS_OUTPUT_SWITCH_SELECT    8'h1C
`define OFS_LOW_THRESHOLD           8'h20
`define OFS_HIGH_THRESHOLD          8'h24
`define OFS_INTERRUPT_ENABLE        8'h28
`define OFS_RAW_INTERRUPT_STATUS    8'h2C
`define OFS_ENABLED_INTERRUPT_STATUS 8'h30
`define OFS_INTERRUPT_CLEAR         8'h34

// ==========================================================
// control register bit positions
`define BIT_SAMPLE_START            0
`define BIT_OUTPUT_START            1
`define BIT_SAMPLE_CONTINUOUS       2
`define BIT_OUTPUT_CONTINUOUS       3
`define BIT_SAMPLE_STOP             4
`define BIT_OUTPUT_STOP             5
`define CONTROL_WIDTH               6

// interrupt bit positions
`define IRQ_OUTPUT_DONE             0
`define IRQ_SAMPLE_READY            1
`define IRQ_BELOW_LOW               2
`define IRQ_ABOVE_HIGH              3
`define IRQ_WIDTH                   4

// ==========================================================
// field widths
`define DATA_WIDTH                  12
`define THRESHOLD_WIDTH             16
`define SETUP_WIDTH                 10
`define SWITCH_WIDTH                20
`define EXTERNAL_LINES              6

// ==========================================================
// reset values
`define RST_CONTROL                 6'h00
`define RST_DATA                    12'h000
`define RST_SETUP                   10'h000
`define RST_SWITCH                  20'h0_0000
`define RST_THRESHOLD               16'h0000
`define RST_ENABLE                  4'h0
`define RST_RAW_STATUS              4'h8

// ==========================================================
// timing: 80 kSamples/s at a 20 MHz clock is one sample start per 250 cycles
`define SAMPLE_PERIOD_CYCLES        16'h00FA

`endif

// *** rtl/conversion_pacer.v ***
// pacing counter that spaces successive sample starts by the sample period
`timescale 1ns/1ps
module conversion_pacer (
    // clock and reset
    input  wire        core_clk_in,
    input  wire        rst_in,
    // control
    input  wire        restart_in,
    // status
    output reg         ready_out
);
`include "sar_converter_map.vh"

    localparam [15:0] PERIOD = `SAMPLE_PERIOD_CYCLES;

    reg [15:0] count;

    // ==========================================================
    // counter
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count     <= 16'h0000;
            ready_out <= 1'b1;
        end else if (restart_in) begin
            count     <= PERIOD - 16'h0001;
            ready_out <= 1'b0;
        end else if (count != 16'h0000) begin
            count     <= count - 16'h0001;
            ready_out <= (count == 16'h0001);
        end
    end

endmodule // conversion_pacer

// *** testbench/conv_core_model.sv ***
// behavioural analog core: answers each go pulse with one done cycle
`timescale 1ns/1ps
module conv_core_model #(parameter LAT = 5) (
    // clock and reset
    input  wire        clk_in,
    input  wire        rst_in,
    // converter link
    input  wire        go_in,
    input  wire [11:0] value_in,
    output reg         done_out,
    output wire [11:0] sample_out
);
    reg [3:0] left;
    // released lines carry the inverse, so a late sample never looks right by chance
    assign sample_out = done_out ? value_in : ~value_in;
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            left     <= 4'h0;
            done_out <= 1'b0;
        end else begin
            done_out <= (left == 4'h1);
            if (go_in)
                left <= LAT[3:0];
            else if (left != 4'h0)
                left <= left - 4'h1;
        end
    end
endmodule // conv_core_model

// *** testbench/sar_ctrl_chk.sv ***
// assertions on the converter control ports
`timescale 1ns/1ps
module sar_ctrl_chk (
    // clock and reset
    input wire        core_clk_in,
    input wire        rst_in,
    // bus handshakes
    input wire        s_axi_awvalid_in,
    input wire        s_axi_awready_out,
    input wire        s_axi_wvalid_in,
    input wire        s_axi_wready_out,
    input wire        s_axi_bvalid_out,
    input wire        s_axi_arvalid_in,
    input wire        s_axi_arready_out,
    input wire        s_axi_rvalid_out,
    // analog core and switches
    input wire        core_sample_go_out,
    input wire        core_output_go_out,
    input wire [11:0] core_output_code_out,
    input wire        core_done_in,
    input wire [19:0] input_switch_out,
    input wire [19:0] output_switch_out
);
    wire      go_any = core_sample_go_out | core_output_go_out;
    reg [8:0] gap;
    // ==========================================
    // cycles since the last sample start, saturating
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in)
            gap <= 9'h1FF;
        else if (core_sample_go_out)
            gap <= 9'h000;
        else if (gap != 9'h1FF)
            gap <= gap + 9'h001;
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    sequence wr_taken;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence rd_taken;
        s_axi_arvalid_in && s_axi_arready_out;
    endsequence
    // ==========================================
    go_exclusive_a: assert property (!(core_sample_go_out && core_output_go_out))
        else $error("both starts at once");
    conv_busy_a: assert property (go_any |=> !go_any until core_done_in)
        else $error("start while core busy");
    go_single_a: assert property (core_sample_go_out |=> !core_sample_go_out)
        else $error("sample go longer than one cycle");
    go_spacing_a: assert property (core_sample_go_out |-> gap >= 9'h0F9)
        else $error("samples closer than the sample period");
    code_hold_a: assert property ($changed(core_output_code_out) |->
        core_output_go_out || $past(core_output_go_out)) else $error("output code moved");
    write_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid_out)
        else $error("write answer late");
    read_answer_a: assert property (rd_taken |-> ##[1:2] s_axi_rvalid_out)
        else $error("read answer late");
    switch_mask_a: assert property ((input_switch_out | output_switch_out) < 20'h0_0040)
        else $error("reserved switch input driven");
endmodule // sar_ctrl_chk

// *** testbench/testbench.sv ***
// self-checking bench of the converter control block
`timescale 1ns/1ps
module testbench;
    reg         clk = 1'b0, rst = 1'b1;
    reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
    reg  [31:0] wdata = 32'h0000_0000, d;
    reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg  [11:0] val = 12'h000;
    reg  [1:0]  r, hist = 2'b00;
    wire        awready, wready, bvalid, arready, rvalid, sgo, ogo, done, irq;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [11:0] code, smp;
    wire [9:0]  setup;
    wire [19:0] insw, outsw;
    integer     fails = 0, checks = 0, ns = 0, no = 0, i, k, m;
    // rows: address, write data, read back, response
    reg  [73:0] rows [0:9] = '{{8'h10, 32'hFFFF_FFFF, 32'h0000_03FF, 2'h0},
        {8'h20, 32'hFFFF_FFFF, 32'h0000_FFFF, 2'h0}, {8'h24, 32'hFFFF_FFFF, 32'h0000_FFFF, 2'h0},
        {8'h08, 32'h0000_0ABC, 32'h0000_0000, 2'h0}, {8'h04, 32'h0000_0555, 32'h0000_0000, 2'h0},
        {8'h28, 32'hFFFF_FFFF, 32'h0000_000F, 2'h0}, {8'h30, 32'h0000_0000, 32'h0000_0008, 2'h0},
        {8'h34, 32'h0000_0008, 32'h0000_0000, 2'h0}, {8'h2C, 32'h0000_0000, 32'h0000_0000, 2'h0},
        {8'h40, 32'h0000_0001, 32'h0000_0000, 2'h2}};
    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (sgo || ogo)
            hist <= {hist[0], ogo};
        if (sgo)
            ns <= ns + 1;
        if (ogo)
            no <= no + 1;
    end
    sar_adc_dac_control sar_adc_dac_control_inst (.core_clk_in(clk), .rst_in(rst),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .core_sample_go_out(sgo),
        .core_output_go_out(ogo), .core_output_code_out(code), .core_done_in(done),
        .core_sample_in(smp), .core_setup_out(setup), .input_switch_out(insw),
        .output_switch_out(outsw), .irq_out(irq));
    conv_core_model conv_core_model_inst (.clk_in(clk), .rst_in(rst), .go_in(sgo | ogo),
        .value_in(val), .done_out(done), .sample_out(smp));
    task wrap_up;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input [31:0] s, input [31:0] e);
        checks = checks + 1;
        if (s !== e) begin
            fails = fails + 1;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // bounded polling, the core and pacer fix no exact latency
    task poll(input [7:0] a, input [31:0] e);
        rd(a);
        for (k = 0; k < 150 && d !== e; k = k + 1)
            rd(a);
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        fails = fails + 1;
        wrap_up;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 10; i = i + 1) begin
            wr(rows[i][73:66], rows[i][65:34]);
            chk(r, rows[i][1:0]);
            rd(rows[i][73:66]);
            chk(d, rows[i][33:2]);
            chk(r, rows[i][1:0]);
        end
        chk(setup, 32'h0000_03FF);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 4; i = i + 1) begin
            rd(8'((32'h2C28_0400 >> (8 * i))));
            chk(d, i == 3 ? 32'h0000_0008 : 32'h0000_0000);
        end
        wr(8'h28, 32'h0000_0008);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        wr(8'h34, 32'h0000_0008);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        wr(8'h18, 32'hFFFF_FFFF);
        wr(8'h1C, 32'hFFFF_FFFF);
        repeat (2) @(posedge clk);
        chk(insw | outsw, 32'h0000_003F);
        wr(8'h20, 32'h0000_0100);
        wr(8'h24, 32'h0000_0800);
        wr(8'h28, 32'h0000_000F);
        for (i = 0; i < 3; i = i + 1) begin
            val <= 12'((36'h4_0090_0050 >> (12 * i)));
            wr(8'h00, 32'h0000_0001);
            poll(8'h00, 32'h0000_0000);
            chk(d, 32'h0000_0000);
            rd(8'h04);
            chk(d, val);
            rd(8'h2C);
            chk(d, (12'h2A6 >> (4 * i)) & 4'hF);
            chk(irq, 1'b1);
            wr(8'h34, 32'h0000_000F);
        end
        wr(8'h08, 32'h0000_0ABC);
        chk(code, 32'h0000_0000);
        wr(8'h00, 32'h0000_0002);
        poll(8'h00, 32'h0000_0000);
        chk(d, 32'h0000_0000);
        chk(code, 32'h0000_0ABC);
        rd(8'h2C);
        chk(d, 32'h0000_0001);
        for (i = 0; i < 2; i = i + 1) begin
            repeat (300) @(posedge clk);
            wr(8'h00, 32'h0000_0003);
            poll(8'h00, 32'h0000_0000);
            chk(hist[1] ^ hist[0], 1'b1);
        end
        chk(hist, 2'b01);
        i = ns;
        m = no;
        wr(8'h00, 32'h0000_000F);
        for (k = 0; k < 2000 && ns < i + 3; k = k + 1)
            @(posedge clk);
        chk(ns >= i + 3 && no >= m + 3, 1'b1);
        wr(8'h00, 32'h0000_003F);
        poll(8'h00, 32'h0000_000C);
        chk(d, 32'h0000_000C);
        i = ns;
        m = no;
        repeat (600) @(posedge clk);
        chk(ns + no, i + m);
        wrap_up;
    end
endmodule // testbench
bind sar_adc_dac_control sar_ctrl_chk sar_ctrl_chk_inst (.core_clk_in, .rst_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bvalid_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
    .core_sample_go_out, .core_output_go_out, .core_output_code_out, .core_done_in,
    .input_switch_out, .output_switch_out);
